// ---- verilog/jcfg_consts.svh ----
`ifndef JCFG_CONSTS_SVH
`define JCFG_CONSTS_SVH

// ---------------------------------------------------------------
// device register map
// ---------------------------------------------------------------
`define JCFG_BAND_REG_ADDR   12'h56E
`define JCFG_STAT_REG_ADDR   12'h570
`define JCFG_BAND_RESET      8'h50

// ---------------------------------------------------------------
// controller register map
// ---------------------------------------------------------------
`define JCFG_HOST_CTRL_ADDR  4'h0
`define JCFG_HOST_STAT_ADDR  4'h1
`define JCFG_HOST_START_BIT  0

// ---------------------------------------------------------------
// lane rate limits and band edges, in kbps
// ---------------------------------------------------------------
`define JCFG_LANE_MIN_KBPS   32'd1687500
`define JCFG_LANE_MAX_KBPS   32'd16000000
`define JCFG_BAND3_LOW_KBPS  32'd13500000
`define JCFG_BAND2_LOW_KBPS  32'd6750000
`define JCFG_BAND1_LOW_KBPS  32'd3375000
`define JCFG_CLK_DIV_RATIO   32'd40

// ---------------------------------------------------------------
// band register codes
// ---------------------------------------------------------------
`define JCFG_CODE_BAND3      8'h30
`define JCFG_CODE_BAND2      8'h00
`define JCFG_CODE_BAND1      8'h10
`define JCFG_CODE_BAND0      8'h50

// ---------------------------------------------------------------
// packing and framing
// ---------------------------------------------------------------
`define JCFG_WORD_BITS       12
`define JCFG_RES_MIN         8
`define JCFG_CTRL_MAX        3
`define JCFG_LANE_MULT       15
`define JCFG_LCM_MAX         64
`define JCFG_K_MAX           32
`define JCFG_K_STEP          4
`define JCFG_DEC_MAX         12

`endif

// ---- verilog/jcfg_pkg.sv ----
`include "jcfg_consts.svh"

package jcfg_pkg;

    typedef logic [31:0] rate_t;
    typedef logic [3:0]  dec_t;

    // lane rate from output rate: converters x 12 x 10/8 / lanes
    function automatic rate_t lane_rate_of(input rate_t orate, input logic [3:0] m,
                                           input logic [2:0] l);
        logic [35:0] prod;
        prod = 36'(`JCFG_LANE_MULT) * 36'(m) * 36'(orate);
        lane_rate_of = (l == 3'd0) ? 32'h0000_0000 : 32'(prod / 36'(l));
    endfunction

    // absolute span and the clock divider relation
    function automatic logic rate_ok(input rate_t lane, input rate_t adc_khz);
        logic [37:0] lim;
        lim = 38'(`JCFG_CLK_DIV_RATIO) * 38'(adc_khz);
        rate_ok = (lane >= `JCFG_LANE_MIN_KBPS) && (lane <= `JCFG_LANE_MAX_KBPS)
                  && (38'(lane) <= lim);
    endfunction

    // band index 0 (slowest) to 3 (fastest)
    function automatic logic [1:0] band_of(input rate_t lane);
        if (lane > `JCFG_BAND3_LOW_KBPS)       band_of = 2'd3;
        else if (lane >= `JCFG_BAND2_LOW_KBPS) band_of = 2'd2;
        else if (lane >= `JCFG_BAND1_LOW_KBPS) band_of = 2'd1;
        else                                   band_of = 2'd0;
    endfunction

    function automatic logic [7:0] band_code(input logic [1:0] band);
        case (band)
            2'd3:    band_code = `JCFG_CODE_BAND3;
            2'd2:    band_code = `JCFG_CODE_BAND2;
            2'd1:    band_code = `JCFG_CODE_BAND1;
            default: band_code = `JCFG_CODE_BAND0;
        endcase
    endfunction

    // lcm(20 x dec x orate / lane, dec) bound; ratio reduces to 4dL/3M
    function automatic logic lcm_ok(input dec_t d, input logic [2:0] l,
                                    input logic [3:0] m);
        int num;
        int den;
        int x;
        lcm_ok = 1'b0;
        num = 4 * int'(d) * int'(l);
        den = 3 * int'(m);
        x = 0;
        if (den != 0 && d != 4'd0 && (num % den) == 0) begin
            x = num / den;
        end
        if (x != 0) begin
            for (int i = 1; i <= `JCFG_LCM_MAX; i++) begin
                if ((i % x) == 0 && (i % int'(d)) == 0) begin
                    lcm_ok = 1'b1;
                end
            end
        end
    endfunction

    // frames per multiframe against octets per frame
    function automatic logic k_ok(input logic [4:0] f, input logic [5:0] k);
        logic [5:0]  kmin;
        logic [10:0] kf;
        logic        step4;
        kf = 11'(k) * 11'(f);
        case (f)
            5'd1:    kmin = 6'd20;
            5'd2:    kmin = 6'd12;
            5'd4:    kmin = 6'd8;
            default: kmin = 6'(`JCFG_K_STEP);
        endcase
        step4 = (f == 5'd1 || f == 5'd2 || f == 5'd4 || f == 5'd8 || f == 5'd16);
        k_ok = (k >= kmin) && (k <= 6'(`JCFG_K_MAX)) && (kf[1:0] == 2'b00)
               && (!step4 || k[1:0] == 2'b00);
    endfunction

endpackage

// ---- verilog/jcfg_if.sv ----
`timescale 1ns/1ps

interface jcfg_if;
    // transport settings published by the converter end
    logic [2:0]  lanes;
    logic [3:0]  convs;
    logic [4:0]  octets;
    logic [3:0]  samples;
    logic        hd;
    logic [5:0]  k;
    logic [3:0]  res;
    logic [1:0]  ctrl_bits;
    logic [31:0] lane_rate;
    logic        link_en;
    // register access into the converter end
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [7:0]  reg_rdata;

    modport dev (output lanes, convs, octets, samples, hd, k, res, ctrl_bits,
                 lane_rate, link_en, reg_rdata,
                 input reg_addr, reg_wdata, reg_we, reg_re);
    modport host (input lanes, convs, octets, samples, hd, k, res, ctrl_bits,
                  lane_rate, link_en, reg_rdata,
                  output reg_addr, reg_wdata, reg_we, reg_re);
endinterface

// ---- verilog/jcfg_dev.sv ----
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module jcfg_dev
    import jcfg_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // requested configuration
    input  wire logic [31:0] i_conv_clk_khz,
    input  wire jcfg_pkg::dec_t i_dec,
    input  wire logic [2:0]  i_lanes,
    input  wire logic [3:0]  i_convs,
    input  wire logic [4:0]  i_octets,
    input  wire logic        i_hd,
    input  wire logic [5:0]  i_k,
    input  wire logic [3:0]  i_res,
    input  wire logic [1:0]  i_ctrl_bits,
    input  wire logic        i_start,
    // status
    output logic             o_cfg_ok,
    output logic             o_link_en,
    output logic             o_band_match,
    output logic [31:0]      o_out_rate_khz,
    output logic [31:0]      o_lane_rate_kbps,
    // link side
    jcfg_if.dev              lnk
);
    import jcfg_pkg::*;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } dev_state_e;

    typedef struct packed {
        dev_state_e  st;
        logic [7:0]  band_reg;
        logic [7:0]  rdata;
        logic [31:0] orate;
        logic [31:0] lane;
        logic        cfg_ok;
        logic        band_match;
        logic [2:0]  lanes;
        logic [3:0]  convs;
        logic [4:0]  octets;
        logic [3:0]  samples;
        logic        hd;
        logic [5:0]  k;
        logic [3:0]  res;
        logic [1:0]  ctrl_bits;
    } dev_s;

    dev_s s_q;
    dev_s s_d;

    // ---------------------------------------------------------------
    // supported modes: samples per frame and per-band decimation masks
    // ---------------------------------------------------------------
    // mask bit n means decimation n+1; bands ordered fastest..slowest
    function automatic logic [51:0] mode_row(input logic [2:0] l, input logic [3:0] m,
                                             input logic [4:0] f, input logic hd);
        case ({l, m, f, hd})
            {3'd1, 4'd1, 5'd3, 1'b0}: mode_row = {4'd2, 48'h000_000_000_004};
            {3'd2, 4'd1, 5'd3, 1'b1}: mode_row = {4'd4, 48'h000_000_000_000};
            {3'd2, 4'd1, 5'd6, 1'b0}: mode_row = {4'd8, 48'h000_000_000_000};
            {3'd3, 4'd1, 5'd1, 1'b1}: mode_row = {4'd2, 48'h000_000_000_001};
            {3'd1, 4'd2, 5'd3, 1'b0}: mode_row = {4'd1, 48'h000_000_004_024};
            {3'd2, 4'd2, 5'd3, 1'b0}: mode_row = {4'd2, 48'h000_000_000_004};
            {3'd3, 4'd2, 5'd1, 1'b1}: mode_row = {4'd1, 48'h000_000_001_007};
            {3'd4, 4'd2, 5'd3, 1'b0}: mode_row = {4'd4, 48'h000_000_000_000};
            {3'd1, 4'd4, 5'd6, 1'b0}: mode_row = {4'd1, 48'h000_004_024_820};
            {3'd2, 4'd4, 5'd3, 1'b0}: mode_row = {4'd1, 48'h000_000_004_024};
            {3'd3, 4'd4, 5'd2, 1'b1}: mode_row = {4'd1, 48'h000_001_007_03A};
            {3'd4, 4'd4, 5'd3, 1'b0}: mode_row = {4'd2, 48'h000_000_000_004};
            {3'd2, 4'd8, 5'd6, 1'b0}: mode_row = {4'd1, 48'h000_000_020_820};
            {3'd4, 4'd8, 5'd3, 1'b0}: mode_row = {4'd1, 48'h000_000_000_020};
            default:                  mode_row = 52'h0_000_000_000_000;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    logic [51:0] row;
    logic [11:0] band_mask;
    logic [1:0]  band;
    logic        dec_ok;
    logic        fmt_ok;

    always_comb begin
        s_d = s_q;
        row = mode_row(i_lanes, i_convs, i_octets, i_hd);
        // output rate seen by the transport layer
        s_d.orate = (i_dec == 4'd0) ? 32'h0000_0000 : i_conv_clk_khz / 32'(i_dec);
        s_d.lane = lane_rate_of(s_d.orate, i_convs, i_lanes);
        band = band_of(s_d.lane);
        band_mask = row[12*band +: 12];
        dec_ok = (i_dec != 4'd0) && (i_dec <= 4'(`JCFG_DEC_MAX))
                 && band_mask[i_dec - 4'd1];
        // sample packed in a 12-bit word: resolution plus control bits
        fmt_ok = (i_res >= 4'(`JCFG_RES_MIN))
                 && (i_ctrl_bits <= 2'(`JCFG_CTRL_MAX))
                 && ({1'b0, i_res} + {3'b000, i_ctrl_bits} <= 5'(`JCFG_WORD_BITS));
        s_d.cfg_ok = dec_ok && fmt_ok
                     && rate_ok(s_d.lane, i_conv_clk_khz)
                     && lcm_ok(i_dec, i_lanes, i_convs)
                     && k_ok(i_octets, i_k);
        // warn when software left the band register on the wrong band
        s_d.band_match = (s_q.band_reg == band_code(band));
        s_d.lanes = i_lanes;
        s_d.convs = i_convs;
        s_d.octets = i_octets;
        s_d.samples = row[51:48];
        s_d.hd = i_hd;
        s_d.k = i_k;
        s_d.res = i_res;
        s_d.ctrl_bits = i_ctrl_bits;

        // link only runs on a configuration judged good a cycle earlier
        case (s_q.st)
            ST_OFF: begin
                if (i_start && s_q.cfg_ok && s_d.cfg_ok && s_d.lane == s_q.lane
                    && s_d.lanes == s_q.lanes && s_d.convs == s_q.convs
                    && s_d.octets == s_q.octets) begin
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!i_start || !s_d.cfg_ok) begin
                    s_d.st = ST_OFF;
                end
            end
            default: s_d.st = ST_OFF;
        endcase

        // register port, read data in the following cycle
        if (lnk.reg_we && lnk.reg_addr == `JCFG_BAND_REG_ADDR) begin
            s_d.band_reg = lnk.reg_wdata;
        end
        s_d.rdata = 8'h00;
        if (lnk.reg_re) begin
            case (lnk.reg_addr)
                `JCFG_BAND_REG_ADDR: s_d.rdata = s_q.band_reg;
                `JCFG_STAT_REG_ADDR: s_d.rdata = {5'b00000, s_q.band_match,
                                                  s_q.cfg_ok, s_q.st == ST_RUN};
                default:             s_d.rdata = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{st: ST_OFF, band_reg: `JCFG_BAND_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign o_cfg_ok         = s_q.cfg_ok;
    assign o_link_en        = s_q.st[1];
    assign o_band_match     = s_q.band_match;
    assign o_out_rate_khz   = s_q.orate;
    assign o_lane_rate_kbps = s_q.lane;
    assign lnk.lanes        = s_q.lanes;
    assign lnk.convs        = s_q.convs;
    assign lnk.octets       = s_q.octets;
    assign lnk.samples      = s_q.samples;
    assign lnk.hd           = s_q.hd;
    assign lnk.k            = s_q.k;
    assign lnk.res          = s_q.res;
    assign lnk.ctrl_bits    = s_q.ctrl_bits;
    assign lnk.lane_rate    = s_q.lane;
    assign lnk.link_en      = s_q.st[1];
    assign lnk.reg_rdata    = s_q.rdata;

endmodule

// ---- verilog/jcfg_host.sv ----
`timescale 1ns/1ps

module jcfg_host
    import jcfg_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // receiver-side knowledge of the converter
    input  wire logic [31:0] i_conv_clk_khz,
    input  wire jcfg_pkg::dec_t i_dec,
    // software port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_we,
    input  wire logic        i_re,
    output logic [7:0]       o_rdata,
    // status
    output logic             o_rx_ok,
    output logic             o_done,
    // link side
    jcfg_if.host             lnk
);
    import jcfg_pkg::*;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RD   = 4'b0100,
        ST_WAIT = 4'b1000
    } host_state_e;

    typedef struct packed {
        host_state_e st;
        logic        done;
        logic        rx_ok;
        logic [7:0]  dev_stat;
        logic [7:0]  code;
        logic [7:0]  rdata;
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } host_s;

    host_s s_q;
    host_s s_d;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.we = 1'b0;
        s_d.re = 1'b0;
        // receiver's own view of the published settings
        s_d.rx_ok = rate_ok(lnk.lane_rate, i_conv_clk_khz)
                    && lcm_ok(i_dec, lnk.lanes, lnk.convs)
                    && k_ok(lnk.octets, lnk.k);

        case (s_q.st)
            ST_IDLE: begin
                if (i_we && i_addr == `JCFG_HOST_CTRL_ADDR
                    && i_wdata[`JCFG_HOST_START_BIT]) begin
                    s_d.done = 1'b0;
                    s_d.st = ST_WR;
                end
            end
            ST_WR: begin
                // band picked from the rate the converter reports
                s_d.code = band_code(band_of(lnk.lane_rate));
                s_d.addr = `JCFG_BAND_REG_ADDR;
                s_d.wdata = s_d.code;
                s_d.we = 1'b1;
                s_d.st = ST_RD;
            end
            ST_RD: begin
                s_d.addr = `JCFG_STAT_REG_ADDR;
                s_d.re = 1'b1;
                s_d.st = ST_WAIT;
            end
            ST_WAIT: begin
                // strobe went out last cycle, data stands now
                if (!s_q.re) begin
                    s_d.dev_stat = lnk.reg_rdata;
                    s_d.done = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // software reads, one cycle after the strobe
        s_d.rdata = 8'h00;
        if (i_re) begin
            case (i_addr)
                `JCFG_HOST_CTRL_ADDR: s_d.rdata = s_q.code;
                `JCFG_HOST_STAT_ADDR: s_d.rdata = {3'b000, s_q.dev_stat[2:0],
                                                   s_q.rx_ok, s_q.done};
                default:              s_d.rdata = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{st: ST_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata       = s_q.rdata;
    assign o_rx_ok       = s_q.rx_ok;
    assign o_done        = s_q.done;
    assign lnk.reg_addr  = s_q.addr;
    assign lnk.reg_wdata = s_q.wdata;
    assign lnk.reg_we    = s_q.we;
    assign lnk.reg_re    = s_q.re;

endmodule

// ---- bench/jcfg_props.sv ----
`timescale 1ns/1ps
`include "jcfg_consts.svh"

// ----------------
// link settings checker
// ----------------
module jcfg_props (
    // clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    // link settings and band writes
    input wire logic [2:0]  lanes,
    input wire logic [3:0]  convs,
    input wire logic [4:0]  octets,
    input wire logic [3:0]  samples,
    input wire logic        hd,
    input wire logic [5:0]  k,
    input wire logic [3:0]  res,
    input wire logic [1:0]  ctrl_bits,
    input wire logic [31:0] lane_rate,
    input wire logic        link_en,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_we
);
    // frame product and band writes
    logic [10:0] kf;
    logic        band_wr;
    assign kf = 11'(k) * 11'(octets);
    assign band_wr = reg_we && reg_addr == 12'h56E;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    lane_span_a: assert property ($rose(link_en) |->
        lane_rate >= `JCFG_LANE_MIN_KBPS && lane_rate <= `JCFG_LANE_MAX_KBPS)
        else $error("link started outside lane rate span");
    word_fit_a: assert property (link_en |->
        res >= 4'h8 && 5'(res) + 5'(ctrl_bits) <= 5'h0C)
        else $error("sample word overflows");
    kf_mult_a: assert property (link_en |-> kf[1:0] == 2'h0)
        else $error("frame product not a multiple of four");
    k_one_a: assert property (link_en && octets == 5'h01 |->
        k >= 6'h14 && k <= 6'h20 && k[1:0] == 2'h0)
        else $error("bad multiframe for one octet");
    k_two_a: assert property (link_en && octets == 5'h02 |->
        k >= 6'h0C && k <= 6'h20 && k[1:0] == 2'h0)
        else $error("bad multiframe for two octets");
    k_four_a: assert property (link_en && octets == 5'h04 |->
        k >= 6'h08 && k <= 6'h20 && k[1:0] == 2'h0)
        else $error("bad multiframe for four octets");
    no_half_a: assert property (!(link_en && lanes == 3'h2 && convs == 4'h1))
        else $error("unsupported two lane mode running");
    one_one_a: assert property (link_en && convs == 4'h1 && lanes == 3'h1 |->
        octets == 5'h03 && samples == 4'h2 && !hd)
        else $error("single lane framing wrong");
    single_hd_a: assert property (link_en && convs == 4'h1 && lanes == 3'h3 |->
        hd && octets == 5'h01 && samples == 4'h2)
        else $error("three lane single framing wrong");
    dual_hd_a: assert property (link_en && convs == 4'h2 && lanes == 3'h3 |->
        hd && octets == 5'h01 && samples == 4'h1)
        else $error("three lane dual framing wrong");
    stable_start_a: assert property ($rose(link_en) |->
        $past(lanes) == lanes && $past(convs) == convs && $past(octets) == octets)
        else $error("link started on unsettled settings");
    band_upper_a: assert property (band_wr && lane_rate >= `JCFG_BAND2_LOW_KBPS |->
        reg_wdata == (lane_rate > `JCFG_BAND3_LOW_KBPS ? 8'h30 : 8'h00))
        else $error("upper band code wrong");
    band_lower_a: assert property (band_wr && lane_rate < `JCFG_BAND2_LOW_KBPS |->
        reg_wdata == (lane_rate >= `JCFG_BAND1_LOW_KBPS ? 8'h10 : 8'h50))
        else $error("lower band code wrong");
endmodule

// ---- bench/jesd_twelve_bit_link_config_tb.sv ----
`timescale 1ns/1ps
`include "jcfg_consts.svh"

module jesd_twelve_bit_link_config_tb;
    import jcfg_pkg::*;

    // ----------------
    // stimulus and observed outputs
    // ----------------
    logic        i_sys_clk = 1'b0;
    logic        i_rst     = 1'b1;
    logic [31:0] conv_khz  = 32'h0;
    dec_t        dec       = 4'h1;
    logic [2:0]  lanes_in  = 3'h1;
    logic [3:0]  convs_in  = 4'h1;
    logic [4:0]  octs_in   = 5'h03;
    logic        hd_in     = 1'b0;
    logic [5:0]  k_in      = 6'h20;
    logic [3:0]  res_in    = 4'hC;
    logic [1:0]  cs_in     = 2'h0;
    logic        start_in  = 1'b0;
    logic [3:0]  sw_addr   = 4'h0;
    logic [7:0]  sw_wdata  = 8'h00;
    logic        sw_we     = 1'b0;
    logic        sw_re     = 1'b0;
    logic [7:0]  sw_rdata;
    logic        cfg_ok, link_on, band_match, rx_ok, done;
    logic [31:0] out_rate, lane_rate;
    int          error_cnt = 0;
    int          compares  = 0;

    // 40 MHz system clock
    always #12.5 i_sys_clk = ~i_sys_clk;

    jcfg_if lnk ();
    jcfg_dev jcfg_dev_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_conv_clk_khz(conv_khz),
        .i_dec(dec), .i_lanes(lanes_in), .i_convs(convs_in), .i_octets(octs_in),
        .i_hd(hd_in), .i_k(k_in), .i_res(res_in), .i_ctrl_bits(cs_in), .i_start(start_in),
        .o_cfg_ok(cfg_ok), .o_link_en(link_on), .o_band_match(band_match),
        .o_out_rate_khz(out_rate), .o_lane_rate_kbps(lane_rate), .lnk(lnk.dev));
    jcfg_host jcfg_host_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_conv_clk_khz(conv_khz),
        .i_dec(dec), .i_addr(sw_addr), .i_wdata(sw_wdata), .i_we(sw_we), .i_re(sw_re),
        .o_rdata(sw_rdata), .o_rx_ok(rx_ok), .o_done(done), .lnk(lnk.host));
    jcfg_props jcfg_props_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .lanes(lnk.lanes),
        .convs(lnk.convs), .octets(lnk.octets), .samples(lnk.samples), .hd(lnk.hd),
        .k(lnk.k), .res(lnk.res), .ctrl_bits(lnk.ctrl_bits), .lane_rate(lnk.lane_rate),
        .link_en(lnk.link_en), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
        .reg_we(lnk.reg_we));

    // ----------------
    // helpers
    // ----------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // band code worked out from the lane rate alone
    function automatic logic [7:0] exp_band(input logic [31:0] r);
        if (r > `JCFG_BAND3_LOW_KBPS) return 8'h30;
        if (r >= `JCFG_BAND2_LOW_KBPS) return 8'h00;
        if (r >= `JCFG_BAND1_LOW_KBPS) return 8'h10;
        return 8'h50;
    endfunction

    // apply settings with start held; returns where the run should be up
    task automatic set_cfg(input logic [31:0] c, input dec_t d, input logic [2:0] l,
        input logic [3:0] m, input logic [4:0] f, input logic h, input logic [5:0] kk,
        input logic [3:0] r, input logic [1:0] cs);
        @(posedge i_sys_clk);
        conv_khz <= c;
        dec      <= d;
        lanes_in <= l;
        convs_in <= m;
        octs_in  <= f;
        hd_in    <= h;
        k_in     <= kk;
        res_in   <= r;
        cs_in    <= cs;
        start_in <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
    endtask

    task automatic sw_write(input logic [3:0] a, input logic [7:0] dat);
        @(posedge i_sys_clk);
        sw_addr  <= a;
        sw_wdata <= dat;
        sw_we    <= 1'b1;
        @(posedge i_sys_clk);
        sw_we    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic sw_read(input logic [3:0] a, output logic [7:0] dat);
        @(posedge i_sys_clk);
        sw_addr <= a;
        sw_re   <= 1'b1;
        @(posedge i_sys_clk);
        sw_re   <= 1'b0;
        @(negedge i_sys_clk);
        dat = sw_rdata;
    endtask

    // legal setting: run comes up, host programs the band, run drops on stop
    task automatic run_legal(input logic [31:0] c, input dec_t d, input logic [2:0] l,
        input logic [3:0] m, input logic [4:0] f, input logic h, input logic [5:0] kk,
        input logic [3:0] r, input logic [1:0] cs, input logic [3:0] s);
        logic [31:0] lr;
        logic [7:0]  rd;
        int          n;
        lr = 32'h0000_000F * m * (c / d) / l;
        set_cfg(c, d, l, m, f, h, kk, r, cs);
        check(cfg_ok, 1'b1);
        check(link_on, 1'b1);
        check(lnk.link_en, 1'b1);
        check(out_rate, c / d);
        check(lane_rate, lr);
        check(lnk.lane_rate, lr);
        check(lnk.samples, s);
        sw_write(4'h0, 8'h01);
        @(negedge i_sys_clk);
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge i_sys_clk);
            n++;
        end
        check(done, 1'b1);
        sw_read(4'h0, rd);
        check(rd, exp_band(lr));
        check(band_match, 1'b1);
        check(rx_ok, 1'b1);
        sw_read(4'h1, rd);
        check(rd & 8'h0F, 8'h0F);
        @(posedge i_sys_clk);
        start_in <= 1'b0;
        repeat (2) @(negedge i_sys_clk);
        check(link_on, 1'b0);
    endtask

    task automatic run_bad(input logic [31:0] c, input dec_t d, input logic [2:0] l,
        input logic [3:0] m, input logic [4:0] f, input logic h, input logic [5:0] kk,
        input logic [3:0] r, input logic [1:0] cs);
        set_cfg(c, d, l, m, f, h, kk, r, cs);
        check(cfg_ok, 1'b0);
        check(link_on, 1'b0);
    endtask

    // ----------------
    // scenarios
    // ----------------
    // slowest band, widest control field that still fits the word
    task automatic t_one_lane();
        run_legal(32'h6DDD0, 4'h3, 3'h1, 4'h1, 5'h03, 1'b0, 6'h20, 4'h9, 2'h3, 4'h2);
    endtask

    task automatic t_single_hd();
        run_legal(32'h61A80, 4'h1, 3'h3, 4'h1, 5'h01, 1'b1, 6'h14, 4'h8, 2'h0, 4'h2);
    endtask

    task automatic t_dual_hd();
        run_legal(32'h61A80, 4'h1, 3'h3, 4'h2, 5'h01, 1'b1, 6'h14, 4'hC, 2'h0, 4'h1);
    endtask

    // smallest multiframe for two octets
    task automatic t_quad_hd();
        run_legal(32'h7A120, 4'h1, 3'h3, 4'h4, 5'h02, 1'b1, 6'h0C, 4'hC, 2'h0, 4'h1);
    endtask

    task automatic t_quad_one();
        run_legal(32'h927C0, 4'h3, 3'h1, 4'h4, 5'h06, 1'b0, 6'h08, 4'h8, 2'h0, 4'h1);
    endtask

    task automatic t_eight();
        run_legal(32'h927C0, 4'h6, 3'h2, 4'h8, 5'h06, 1'b0, 6'h04, 4'hA, 2'h1, 4'h1);
    endtask

    // each setting breaks one limit, except the first and fourth, which break two each
    task automatic t_refuse();
        run_bad(32'h6DDD0, 4'h3, 3'h2, 4'h1, 5'h03, 1'b1, 6'h20, 4'hC, 2'h0);
        run_bad(32'h61A80, 4'h1, 3'h3, 4'h2, 5'h01, 1'b1, 6'h10, 4'hC, 2'h0);
        run_bad(32'h493E0, 4'h3, 3'h1, 4'h1, 5'h03, 1'b0, 6'h20, 4'hC, 2'h0);
        run_bad(32'h6DDD0, 4'h1, 3'h1, 4'h1, 5'h03, 1'b0, 6'h20, 4'hC, 2'h0);
        run_bad(32'h6DDD0, 4'h3, 3'h1, 4'h1, 5'h03, 1'b0, 6'h20, 4'hC, 2'h1);
        run_bad(32'h927C0, 4'h3, 3'h1, 4'h4, 5'h06, 1'b0, 6'h05, 4'hC, 2'h0);
        run_bad(32'h7A120, 4'h1, 3'h3, 4'h4, 5'h02, 1'b1, 6'h08, 4'hC, 2'h0);
    endtask

    // unmapped read, then reset in mid-run
    task automatic t_reset();
        logic [7:0] rd;
        sw_read(4'h7, rd);
        check(rd, 8'h00);
        set_cfg(32'h6DDD0, 4'h3, 3'h1, 4'h1, 5'h03, 1'b0, 6'h20, 4'hC, 2'h0);
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (2) @(negedge i_sys_clk);
        check(link_on, 1'b0);
        check(cfg_ok, 1'b0);
        @(posedge i_sys_clk);
        i_rst    <= 1'b0;
        start_in <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_one_lane();
        t_single_hd();
        t_dual_hd();
        t_quad_hd();
        t_quad_one();
        t_eight();
        t_refuse();
        t_reset();
        close_out();
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        close_out();
    end
endmodule
